// file: rtl/fso_pkg.sv
/*
 fso_pkg: constants shared by the fast shut-off zone logic.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package fso_pkg;
	localparam int          MAX_INPUTS       = 8;
	localparam int          MAX_INPUTS_BYP   = 7;
	localparam logic [1:0]  ZONE_NONE        = 2'h0;
	localparam logic [1:0]  ZONE_ONE         = 2'h1;
	localparam logic [1:0]  ZONE_TWO         = 2'h2;
	localparam logic [1:0]  ZONE_BOTH        = 2'h3;
	localparam int          BYPASS_DELAY     = 3;
	localparam logic [1:0]  BYPASS_CNT_RESET = 2'h0;
	localparam logic [3:0]  NUM_INPUTS_RESET = 4'h1;
	localparam logic [15:0] ZONE_CFG_RESET   = 16'h0000;
	// slow path latency standing in for the application response time, in logic cycles
	localparam int          SLOW_DELAY       = 2;
	localparam logic [2:0]  SLOW_CNT_RESET   = 3'h0;
	localparam logic [3:0]  REG_CFG          = 4'h0;
	localparam logic [3:0]  REG_ZONE         = 4'h1;
	localparam logic [3:0]  REG_STATUS       = 4'h2;
	localparam int          CFG_NUM_LSB      = 0;
	localparam int          CFG_BYP_BIT      = 4;
	localparam int          CFG_EN_BIT       = 5;
	localparam int          STS_ZONE1_BIT    = 0;
	localparam int          STS_ZONE2_BIT    = 1;
	localparam int          STS_ENABLE_BIT   = 2;
	localparam int          STS_BYPASS_BIT   = 3;
	localparam int          STS_OUT_BIT      = 4;
endpackage : fso_pkg

// file: rtl/fso_zone_if.sv
/*
 fso_zone_if: carries raw inputs, the used mask and zone settings to the zone combiner.
 assumes: a single clock domain.
*/
`timescale 1ns/1ps
interface fso_zone_if;
	logic [7:0]  inputs;
	logic [7:0]  used;
	logic [15:0] zone_cfg;
	logic        zone1;
	logic        zone2;
	logic        enable;
	modport ctrl (output inputs, output used, output zone_cfg, input zone1, input zone2, input enable);
	modport comb (input inputs, input used, input zone_cfg, output zone1, output zone2, output enable);
endinterface : fso_zone_if

// file: rtl/fso_zone_comb.sv
/*
 fso_zone_comb: ands inputs per zone and ors the two zone results.
 assumes: used marks configured input positions; purely combinational.
*/
`timescale 1ns/1ps
module fso_zone_comb (
	fso_zone_if.comb zb
);
	logic [7:0] in_z1;
	logic [7:0] in_z2;
	logic [7:0] t_z1;
	logic [7:0] t_z2;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_in
			assign in_z1[g] = zb.used[g] && zb.zone_cfg[2*g];     // R6
			assign in_z2[g] = zb.used[g] && zb.zone_cfg[2*g+1];   // R6
			assign t_z1[g]  = !in_z1[g] || zb.inputs[g];          // R4
			assign t_z2[g]  = !in_z2[g] || zb.inputs[g];          // R4
		end
	endgenerate

	// an empty zone must not hold the output on
	assign zb.zone1  = (|in_z1) && (&t_z1);   // R14
	assign zb.zone2  = (|in_z2) && (&t_z2);   // R14
	assign zb.enable = zb.zone1 || zb.zone2;  // R5
endmodule : fso_zone_comb

// file: rtl/fast_shutoff_zone_logic.sv
/*
 fast_shutoff_zone_logic: fast shut-off of one output from up to eight safety inputs.
 assumes: inputs synchronous to i_clk_sys; one clock per logic cycle when i_ce is high.
*/
// What this block does
// R1: plain variant takes one to eight inputs
// R2: bypass variant takes one to seven inputs
// R3: shut-off acts at once, bypassing logic cycle
// R4: inputs in one zone are ANDed
// R5: zone results ORed; drop triggers shut-off
// R6: per-input zone setting one, two, both
// R7: active bypass suppresses the shut-off
// R8: target output lives on same module
// R9: downstream gating must pass a low through
// R10: inputs alone must also switch output off
// R11: state output only indicates, never drives
// R12: bypass counts after three high cycles
// R13: bypass release shuts off at normal speed
// R14: empty zone contributes false
`timescale 1ns/1ps
module fast_shutoff_zone_logic (
	// clock, reset, enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	// safety inputs, position after the last used input is the bypass in bypass mode
	input  wire logic [7:0]  i_safety_in,
	// result of the ordinary application logic for the target output
	input  wire logic        i_logic_out,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// outputs
	output logic             o_phys_out,
	output logic             o_state
);
	logic [3:0]  num_inputs;
	logic        bypass_mode;
	logic        out_en;
	logic [15:0] zone_cfg;
	logic [1:0]  byp_cnt;
	logic        byp_active;
	logic [2:0]  slow_cnt;
	logic        slow_hold;
	logic [7:0]  used;
	logic [3:0]  eff_num;
	logic [7:0]  byp_sel;
	logic        byp_raw;
	logic        fast_ok;

	fso_zone_if zb ();
	fso_zone_comb u_comb (.zb(zb));

	// bypass variant loses one position, so cap the count at seven
	always_comb begin
		eff_num = num_inputs;
		if (num_inputs == 4'h0)
			eff_num = 4'h1;                                          // R1
		else if (bypass_mode && num_inputs > 4'(fso_pkg::MAX_INPUTS_BYP))
			eff_num = 4'(fso_pkg::MAX_INPUTS_BYP);                   // R2
		else if (num_inputs > 4'(fso_pkg::MAX_INPUTS))
			eff_num = 4'(fso_pkg::MAX_INPUTS);                       // R1
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_used
			assign used[g]    = (4'(g) < eff_num);                     // R1
			assign byp_sel[g] = (4'(g) == eff_num);                    // R2
		end
	endgenerate

	// bypass sits in the first position after the safety inputs
	assign byp_raw     = bypass_mode && |(byp_sel & i_safety_in);   // R2
	assign zb.inputs   = i_safety_in;
	assign zb.used     = used;
	assign zb.zone_cfg = zone_cfg;

	// bypass qualification: three consecutive high logic cycles
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			byp_cnt    <= fso_pkg::BYPASS_CNT_RESET;
			byp_active <= 1'b0;
		end else if (i_ce) begin
			if (!byp_raw) begin
				byp_cnt    <= fso_pkg::BYPASS_CNT_RESET;
				byp_active <= 1'b0;
			end else if (byp_cnt < 2'(fso_pkg::BYPASS_DELAY - 1)) begin
				byp_cnt <= byp_cnt + 2'h1;                           // R12
			end else begin
				byp_active <= 1'b1;                                  // R12
			end
		end
	end

	// after bypass falls the output only drops at normal speed
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			slow_cnt <= fso_pkg::SLOW_CNT_RESET;
		end else if (i_ce) begin
			if (byp_active)
				slow_cnt <= 3'(fso_pkg::SLOW_DELAY);                 // R13
			else if (slow_cnt != 3'h0)
				slow_cnt <= slow_cnt - 3'h1;                         // R13
		end
	end
	assign slow_hold = (slow_cnt != 3'h0);

	// combinational path so the cut does not wait for a logic cycle
	assign fast_ok = zb.enable || byp_active || slow_hold;          // R3 R7 R13

	// target gated by and only, so a low from either side wins
	always_comb begin
		o_phys_out = out_en && i_logic_out && fast_ok;              // R3 R9
	end

	// indication only; not the drive of the target
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			o_state <= 1'b0;
		else if (i_ce)
			o_state <= zb.enable || byp_active;                      // R11
	end

	// configuration registers
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			num_inputs  <= fso_pkg::NUM_INPUTS_RESET;
			bypass_mode <= 1'b0;
			out_en      <= 1'b0;
			zone_cfg    <= fso_pkg::ZONE_CFG_RESET;
		end else if (i_ce && i_wr) begin
			case (i_addr)
				fso_pkg::REG_CFG: begin
					num_inputs  <= i_wdata[fso_pkg::CFG_NUM_LSB +: 4];
					bypass_mode <= i_wdata[fso_pkg::CFG_BYP_BIT];
					out_en      <= i_wdata[fso_pkg::CFG_EN_BIT];
				end
				fso_pkg::REG_ZONE: begin
					zone_cfg <= i_wdata[15:0];                       // R6
				end
				default: begin
				end
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				case (i_addr)
					fso_pkg::REG_CFG:
						o_rdata <= {26'h000_0000, out_en, bypass_mode, num_inputs};
					fso_pkg::REG_ZONE:
						o_rdata <= {16'h0000, zone_cfg};
					fso_pkg::REG_STATUS:
						o_rdata <= {27'h000_0000, o_phys_out, byp_active, zb.enable, zb.zone2, zb.zone1};
					default:
						o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : fast_shutoff_zone_logic

// file: verification/fso_properties.sv
/* fso_properties: port checks of the shut-off block.
 assumes: bound into fast_shutoff_zone_logic, bypass pin stable per test. */
`timescale 1ns/1ps
module fso_properties (
	input wire logic        i_clk_sys, i_nrst, i_ce, i_logic_out, i_wr, i_rd,
	input wire logic        o_phys_out, o_state,
	input wire logic [7:0]  i_safety_in,
	input wire logic [3:0]  i_addr,
	input wire logic [31:0] i_wdata, o_rdata
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	logic [31:0] cfg, zn;
	logic [1:0]  bc;
	logic        ba, en, a1, a2, h1, h2;
	int          n;
	// shadow copies of the settings, so expectations need no peek inside
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg <= 32'h0000_0001;
			zn <= 32'h0000_0000;
			bc <= 2'h0;
		end else if (i_ce) begin
			if (i_wr && i_addr == fso_pkg::REG_CFG) cfg <= i_wdata;
			if (i_wr && i_addr == fso_pkg::REG_ZONE) zn <= i_wdata;
			bc <= (!cfg[4] || !i_safety_in[n]) ? 2'h0 : bc + {1'b0, bc != 2'h3};
		end
	end
	assign ba = bc == 2'h3;
	always_comb begin
		n = cfg[3:0] == 4'h0 ? 1 : cfg[3:0] > 4'h8 ? 8 : int'(cfg[3:0]);
		if (cfg[4] && n > 7) n = 7;
		{a1, a2, h1, h2} = 4'hc;
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				a1 &= i_safety_in[i] | !zn[2*i];
				a2 &= i_safety_in[i] | !zn[2*i+1];
				h1 |= zn[2*i];
				h2 |= zn[2*i+1];
			end
		end
		en = (a1 & h1) | (a2 & h2);
	end
	sequence s_on;
		cfg[4] && cfg[5] && i_logic_out;
	endsequence
	chk_logic_gate: assert property (!i_logic_out |-> !o_phys_out) else $error("output on without logic");
	chk_en_off: assert property (!cfg[5] |-> !o_phys_out) else $error("output on while disabled");
	chk_zone_fast: assert property (!cfg[4] |-> o_phys_out == (cfg[5] & i_logic_out & en))
		else $error("zone result not on output");
	chk_state_track: assert property (!cfg[4] && $past(i_ce) |-> o_state == $past(en))
		else $error("state not zone result");
	chk_read_status: assert property ($past(i_rd && i_ce && i_addr == fso_pkg::REG_STATUS) |->
		o_rdata[4:2] == $past({o_phys_out, ba, en})) else $error("status read wrong");
	chk_bypass_hold: assert property (s_on ##0 ba |-> o_phys_out) else $error("bypass did not hold");
	chk_bypass_early: assert property (cfg[4] && !en && !ba && !$past(ba) && !$past(ba, 2) && !$past(ba, 3)
		|-> !o_phys_out) else $error("bypass took effect early");
	chk_bypass_slow: assert property (s_on ##0 $fell(ba) |-> o_phys_out) else $error("bypass release fast");
endmodule : fso_properties
bind fast_shutoff_zone_logic fso_properties u_chk (.*);

// file: verification/fso_field.sv
/* fso_field: light barriers whose lines feed the safety inputs.
 assumes: beams set by the bench; one cycle sensor delay. */
`timescale 1ns/1ps
module fso_field (
	input wire logic       i_clk_sys,
	input wire logic [7:0] i_beam,
	output logic     [7:0] o_line
);
	// every line lands on the module that holds the target output
	always_ff @(posedge i_clk_sys) o_line <= i_beam;
endmodule : fso_field

// file: verification/fast_shutoff_zone_logic_tb.sv
/* fast_shutoff_zone_logic_tb: random and corner tests of the shut-off block.
 assumes: fso_field drives the inputs, checker bound by its own file. */
`timescale 1ns/1ps
module fast_shutoff_zone_logic_tb;
	logic        clk = 0, nrst = 0, ce = 1, lo = 1, wr = 0, rd = 0, ph, st;
	logic [7:0]  beam = 0, sin;
	logic [3:0]  addr = 0;
	logic [31:0] wd = 0, rdat;
	int          error_cnt = 0, checked = 0;
	always #2 clk = ~clk;
	fso_field u_fld (.i_clk_sys(clk), .i_beam(beam), .o_line(sin));
	fast_shutoff_zone_logic dut (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce), .i_safety_in(sin), .i_logic_out(lo),
		.i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_phys_out(ph), .o_state(st));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 cmp(rdat, e);
	endtask : rreg
	// returns enable, zone two, zone one
	function automatic logic [2:0] zen(logic [7:0] b, logic [15:0] z, int n);
		logic a1, a2, h1, h2;
		{a1, a2, h1, h2} = 4'hc;
		for (int i = 0; i < n; i++) begin
			a1 &= b[i] | !z[2*i];
			a2 &= b[i] | !z[2*i+1];
			h1 |= z[2*i];
			h2 |= z[2*i+1];
		end
		return {(a1 & h1) | (a2 & h2), a2 & h2, a1 & h1};
	endfunction : zen
	task automatic results();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	initial begin
		#100000;
		error_cnt++;
		results();
	end
	initial begin
		int n;
		logic [15:0] z;
		logic [2:0] e;
		n = $urandom(6455);
		repeat (16) @(posedge clk);
		nrst <= 1;
		rreg(fso_pkg::REG_CFG, 32'h0000_0001);
		rreg(fso_pkg::REG_ZONE, 32'h0000_0000);
		rreg(fso_pkg::REG_STATUS, 32'h0000_0000);
		rreg(4'hf, 32'h0000_0000);
		ce <= 0;
		wreg(fso_pkg::REG_CFG, 32'h0000_0023);
		ce <= 1;
		rreg(fso_pkg::REG_CFG, 32'h0000_0001);
		$display("register test done");
		for (int k = 0; k < 60; k++) begin
			n = k < 2 ? 8 : $urandom_range(8, 1);
			z = k == 0 ? 16'h0000 : k == 1 ? 16'hffff : 16'($urandom);
			beam <= k == 1 ? 8'hff : 8'($urandom);
			lo <= k < 2 || 1'($urandom);
			wreg(fso_pkg::REG_CFG, 32'h0000_0020 | n);
			wreg(fso_pkg::REG_ZONE, {16'h0000, z});
			e = zen(beam, z, n);
			// the zone word landed on the last wreg edge and the state flop follows on this edge
			@(posedge clk);
			#1 cmp(ph, e[2] & lo);
			cmp(st, e[2]);
			rreg(fso_pkg::REG_STATUS, {27'h000_0000, e[2] & lo, 1'b0, e});
		end
		$display("zone test done");
		beam <= 8'h00;
		lo <= 1;
		wreg(fso_pkg::REG_ZONE, 32'h0000_0015);
		wreg(fso_pkg::REG_CFG, 32'h0000_0033);
		beam <= 8'h08;
		repeat (3) @(posedge clk);
		#1 cmp(ph, 1'b0);
		repeat (2) @(posedge clk);
		#1 cmp(ph, 1'b1);
		@(posedge clk);
		beam <= 8'h00;
		repeat (3) @(posedge clk);
		#1 cmp(ph, 1'b1);
		repeat (4) @(posedge clk);
		#1 cmp(ph, 1'b0);
		$display("bypass test done");
		results();
	end
endmodule : fast_shutoff_zone_logic_tb
